//--- abc_consts.svh
// Constants for the auxiliary bus control block: offsets, fields, reset values and counts.
// Assumes inclusion by bare name from the package and the design file.
`ifndef ABC_CONSTS_SVH
`define ABC_CONSTS_SVH

// Register indices; the byte address is four times the index.
`define ABC_AUX_IDX 12'h008E
`define ABC_STAT_IDX 12'h008F
`define ABC_ADDR_W 12

// Field positions of the auxiliary register.
`define ABC_AUX_QUIET 0
`define ABC_AUX_EXTSEL 1
`define ABC_AUX_SIZE_LO 2
`define ABC_AUX_SIZE_HI 3
`define ABC_AUX_STRETCH 5
`define ABC_AUX_PULLDIS 7

// Reset value with the two reserved bits read as zero, and the writable bit mask.
`define ABC_AUX_RESET 8'h0C
`define ABC_AUX_WMASK 8'hAF

// Address latch strobe periods in oscillator clocks.
`define ABC_ALE_PERIOD 3'h6
`define ABC_ALE_PERIOD_X2 3'h3

// Read and write strobe lengths in clock periods.
`define ABC_STROBE_SHORT 5'h06
`define ABC_STROBE_LONG 5'h1E

// Bus responses.
`define ABC_RESP_OKAY 2'h0
`define ABC_RESP_SLVERR 2'h2

`endif

//--- abc_pkg.sv
// Types shared by the auxiliary bus control block.
// Assumes the constants header is on the include path.
`default_nettype none
`include "abc_consts.svh"

package abc_pkg;

  // Strobe sequencer states.
  typedef enum logic {
    ABC_IDLE,
    ABC_STROBE
  } abc_strb_t;

  // Complete state of the block.
  typedef struct packed {
    logic [7:0] aux;
    logic [2:0] div;
    logic ale;
    logic ale_oe;
    abc_strb_t strb;
    logic [4:0] cnt;
    logic rd_n;
    logic wr_n;
    logic expanded_ram_stb;
    logic aw_got;
    logic w_got;
    logic [`ABC_ADDR_W-1:0] waddr;
    logic [7:0] wdata;
    logic wlane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } abc_state_t;

endpackage
`default_nettype wire

//--- abc_top.sv
// Auxiliary control of the external memory port: address latch strobe, read and
// write strobe stretching, expanded RAM size, data routing and pull-up disable.
// Assumes one 25 MHz clock, inputs synchronous to it, and an AXI4-Lite master.
`timescale 1ns/100ps
`default_nettype none
`include "abc_consts.svh"

module abc_top (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // AXI4-Lite write channels.
  input wire logic [`ABC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [`ABC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core side.
  input wire logic double_speed_mode,
  input wire logic code_ext_active,
  input wire logic external_data_move_req,
  input wire logic external_data_move_write,
  output logic external_data_move_busy,
  output logic expanded_ram_stb,
  output logic [10:0] expanded_ram_size_bytes,
  // Memory port pins.
  output logic ale_out,
  output logic ale_oe,
  output logic ale_pullup,
  output logic rd_n,
  output logic wr_n,
  output logic pullup_en
);
  import abc_pkg::*;

  abc_state_t st;
  abc_state_t next_st;
  logic ale_drive;
  logic [2:0] period;
  logic [4:0] len;

  // Decodes a byte address to 1 for the auxiliary register, 2 for status, 0 for none.
  function automatic logic [1:0] reg_sel(input logic [`ABC_ADDR_W-1:0] a);
    if (a[1:0] != 2'h0) begin
      reg_sel = 2'h0;
    end else if ({2'h0, a[`ABC_ADDR_W-1:2]} == `ABC_AUX_IDX) begin
      reg_sel = 2'h1;
    end else if ({2'h0, a[`ABC_ADDR_W-1:2]} == `ABC_STAT_IDX) begin
      reg_sel = 2'h2;
    end else begin
      reg_sel = 2'h0;
    end
  endfunction

  // Expanded RAM size in bytes: 256 times the field value plus one.
  function automatic logic [10:0] size_bytes(input logic [1:0] code);
    size_bytes = {code + 2'h1 == 2'h0 ? 1'b1 : 1'b0, code + 2'h1, 8'h00};
  endfunction

  // Ready terms are combinational; one outstanding write and read at a time.
  assign s_axi_awready = !st.aw_got && !st.bvalid;
  assign s_axi_wready = !st.w_got && !st.bvalid;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rdata = {24'h00_0000, st.rdata};

  // Pin and core outputs straight from the state flops.
  assign ale_out = st.ale;
  assign ale_oe = st.ale_oe;
  assign rd_n = st.rd_n;
  assign wr_n = st.wr_n;
  assign expanded_ram_stb = st.expanded_ram_stb;
  assign external_data_move_busy = (st.strb != ABC_IDLE);
  assign ale_pullup = !st.ale_oe;
  assign pullup_en = !st.aux[`ABC_AUX_PULLDIS];
  assign expanded_ram_size_bytes = size_bytes(st.aux[`ABC_AUX_SIZE_HI:`ABC_AUX_SIZE_LO]);

  assign period = double_speed_mode ? `ABC_ALE_PERIOD_X2 : `ABC_ALE_PERIOD;
  assign len = st.aux[`ABC_AUX_STRETCH] ? `ABC_STROBE_LONG : `ABC_STROBE_SHORT;
  // Drive the latch strobe unless quiet with no external activity.
  assign ale_drive = !st.aux[`ABC_AUX_QUIET] || code_ext_active || external_data_move_req || (st.strb != ABC_IDLE);

  // Next state of the whole block.
  always_comb begin
    next_st = st;
    // The divider runs free so the strobe phase stays steady when it is re-enabled.
    next_st.div = (st.div >= period - 3'h1) ? 3'h0 : st.div + 3'h1;
    next_st.ale = (next_st.div == 3'h0) && ale_drive;
    next_st.ale_oe = ale_drive;
    next_st.expanded_ram_stb = 1'b0;

    // Strobe sequencer; a request while busy is ignored.
    case (st.strb)
      ABC_IDLE: begin
        if (external_data_move_req) begin
          if (st.aux[`ABC_AUX_EXTSEL]) begin
            next_st.strb = ABC_STROBE;
            next_st.cnt = len - 5'h01;
            next_st.rd_n = external_data_move_write;
            next_st.wr_n = !external_data_move_write;
          end else begin
            next_st.expanded_ram_stb = 1'b1;
          end
        end
      end
      ABC_STROBE: begin
        // Hold low for the full count.
        if (st.cnt == 5'h00) begin
          next_st.strb = ABC_IDLE;
          next_st.rd_n = 1'b1;
          next_st.wr_n = 1'b1;
        end else begin
          next_st.cnt = st.cnt - 5'h01;
        end
      end
      default: begin
        next_st.strb = ABC_IDLE;
      end
    endcase

    // Write path: address and data may arrive in either order.
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.aw_got = 1'b1;
      next_st.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata[7:0];
      next_st.wlane = s_axi_wstrb[0];
    end
    if (next_st.aw_got && next_st.w_got) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = `ABC_RESP_OKAY;
      if (reg_sel(next_st.waddr) == 2'h1) begin
        if (next_st.wlane) begin
          next_st.aux = next_st.wdata & `ABC_AUX_WMASK;
        end
      end else if (reg_sel(next_st.waddr) == 2'h2) begin
        next_st.bresp = `ABC_RESP_OKAY;
      end else begin
        next_st.bresp = `ABC_RESP_SLVERR;
      end
    end

    // Read path answers one cycle after the address is taken.
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = `ABC_RESP_OKAY;
      if (reg_sel(s_axi_araddr) == 2'h1) begin
        next_st.rdata = st.aux;
      end else if (reg_sel(s_axi_araddr) == 2'h2) begin
        next_st.rdata = {5'h00, st.ale_oe, st.ale, external_data_move_busy};
      end else begin
        next_st.rdata = 8'h00;
        next_st.rresp = `ABC_RESP_SLVERR;
      end
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
      st.aux <= `ABC_AUX_RESET;
      st.strb <= ABC_IDLE;
      st.rd_n <= 1'b1;
      st.wr_n <= 1'b1;
      st.ale_oe <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Helper for the strobe length check: counts low cycles, keeps the expected length.
  logic [4:0] low_len;
  logic [4:0] exp_len;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_len <= 5'h00;
      exp_len <= 5'h00;
    end else begin
      low_len <= (!st.rd_n || !st.wr_n) ? low_len + 5'h01 : 5'h00;
      if (st.strb == ABC_IDLE && external_data_move_req && st.aux[`ABC_AUX_EXTSEL]) begin
        exp_len <= len;
      end
    end
  end

  property p_quiet_off;
    @(posedge clk) disable iff (!rst_b)
    (st.aux[0] && !code_ext_active && !external_data_move_req && st.strb == ABC_IDLE) |=> !ale_oe && !ale_out;
  endproperty
  a_quiet_off: assert property (p_quiet_off) else $error("latch strobe driven while quiet");

  property p_ext_on;
    @(posedge clk) disable iff (!rst_b)
    (code_ext_active || external_data_move_busy) |=> ale_oe;
  endproperty
  a_ext_on: assert property (p_ext_on) else $error("latch strobe released during external access");

  property p_weak_pull;
    @(posedge clk) disable iff (!rst_b)
    !ale_oe |-> ale_pullup && !ale_out;
  endproperty
  a_weak_pull: assert property (p_weak_pull) else $error("released strobe not pulled high");

  property p_rate_x1;
    @(posedge clk) disable iff (!rst_b)
    (ale_out && !double_speed_mode && !st.aux[0]) ##1 (!double_speed_mode && !st.aux[0] && !ale_out)[*5] |=> ale_out;
  endproperty
  a_rate_x1: assert property (p_rate_x1) else $error("latch strobe period not six");

  property p_rate_x2;
    @(posedge clk) disable iff (!rst_b)
    (ale_out && double_speed_mode && !st.aux[0]) ##1 (double_speed_mode && !st.aux[0])[*2] |=> ale_out;
  endproperty
  a_rate_x2: assert property (p_rate_x2) else $error("latch strobe period not three");

  property p_pull_dis;
    @(posedge clk) disable iff (!rst_b)
    $rose(s_axi_bvalid) && reg_sel(st.waddr) == 2'h1 && st.wlane |-> pullup_en == !st.wdata[7];
  endproperty
  a_pull_dis: assert property (p_pull_dis) else $error("pull-up enable not following write");

  property p_strobe_len;
    @(posedge clk) disable iff (!rst_b)
    $rose(rd_n && wr_n) |-> low_len == exp_len && (exp_len == `ABC_STROBE_SHORT || exp_len == `ABC_STROBE_LONG);
  endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("strobe length wrong");

  property p_size;
    @(posedge clk) disable iff (!rst_b)
    $rose(s_axi_bvalid) && reg_sel(st.waddr) == 2'h1 && st.wlane && st.wdata[3:2] == 2'h0 |-> expanded_ram_size_bytes == 11'h100;
  endproperty
  a_size: assert property (p_size) else $error("size code zero not 256 bytes");

  property p_route;
    @(posedge clk) disable iff (!rst_b)
    (external_data_move_req && !external_data_move_busy) |=> (expanded_ram_stb == !$past(st.aux[1])) && ((rd_n && wr_n) == !$past(st.aux[1]));
  endproperty
  a_route: assert property (p_route) else $error("data move routed wrongly");

  property p_reserved;
    @(posedge clk) disable iff (!rst_b)
    (s_axi_arvalid && s_axi_arready && reg_sel(s_axi_araddr) == 2'h1) |=> s_axi_rdata[6] == 1'b0 && s_axi_rdata[4] == 1'b0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");

  // Further guards on the size decode, the strobe pins and the data move routing.
  property p_size_map;
    @(posedge clk) disable iff (!rst_b)
    expanded_ram_size_bytes == (st.aux[`ABC_AUX_SIZE_HI:`ABC_AUX_SIZE_LO] == 2'h0 ? 11'h100 :
      st.aux[`ABC_AUX_SIZE_HI:`ABC_AUX_SIZE_LO] == 2'h1 ? 11'h200 :
      st.aux[`ABC_AUX_SIZE_HI:`ABC_AUX_SIZE_LO] == 2'h2 ? 11'h300 : 11'h400);
  endproperty
  a_size_map: assert property (p_size_map) else $error("size decode wrong");

  property p_read_strobe;
    @(posedge clk) disable iff (!rst_b)
    (external_data_move_req && !external_data_move_busy && st.aux[`ABC_AUX_EXTSEL] && !external_data_move_write) |=> !rd_n && wr_n && external_data_move_busy;
  endproperty
  a_read_strobe: assert property (p_read_strobe) else $error("read strobe not started");

  property p_write_strobe;
    @(posedge clk) disable iff (!rst_b)
    (external_data_move_req && !external_data_move_busy && st.aux[`ABC_AUX_EXTSEL] && external_data_move_write) |=> !wr_n && rd_n && external_data_move_busy;
  endproperty
  a_write_strobe: assert property (p_write_strobe) else $error("write strobe not started");

  property p_no_overlap;
    @(posedge clk) disable iff (!rst_b)
    rd_n || wr_n;
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("read and write strobes low together");

  // The past value is used because a write may clear the quiet bit while the pin is still released.
  property p_release_quiet;
    @(posedge clk) disable iff (!rst_b)
    !ale_oe |-> $past(st.aux[`ABC_AUX_QUIET]);
  endproperty
  a_release_quiet: assert property (p_release_quiet) else $error("strobe pin released while not quiet");

  property p_x1_drive;
    @(posedge clk) disable iff (!rst_b)
    !st.aux[`ABC_AUX_QUIET] |=> ale_oe;
  endproperty
  a_x1_drive: assert property (p_x1_drive) else $error("strobe pin not driven with quiet bit clear");

  property p_pulse_one;
    @(posedge clk) disable iff (!rst_b)
    ale_out |=> !ale_out;
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("latch strobe pulse longer than one clock");

  property p_expanded_ram_cause;
    @(posedge clk) disable iff (!rst_b)
    expanded_ram_stb |-> $past(external_data_move_req) && !$past(external_data_move_busy) && !$past(st.aux[`ABC_AUX_EXTSEL]);
  endproperty
  a_expanded_ram_cause: assert property (p_expanded_ram_cause) else $error("internal RAM strobe without internal move");

endmodule
`default_nettype wire

//--- abc_mem_model.sv
// Behavioural external memory on the multiplexed port: times the read and write
// strobes and counts latch strobe pulses. Assumes pins synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module abc_mem_model (
  // Clock and counter clear.
  input wire logic clk,
  input wire logic clr,
  // Memory port pins.
  input wire logic ale_out,
  input wire logic ale_oe,
  input wire logic ale_pullup,
  input wire logic rd_n,
  input wire logic wr_n,
  // Measurements.
  output logic [5:0] last_len,
  output logic [15:0] ale_cnt
);
  logic [5:0] run;
  logic ale_wire;
  // weak pull-up
  // A released pin floats up through the pull-up, so the wire reads high then.
  assign ale_wire = ale_oe ? ale_out : ale_pullup;
  // Only driven pulses count; a pulled-up level latches no address.
  always_ff @(posedge clk) begin
    if (clr) begin
      ale_cnt <= 16'h0000;
    end else if (ale_oe && ale_wire) begin
      ale_cnt <= ale_cnt + 16'h0001;
    end
  end
  // strobe length
  // One timer serves both strobes, since only one move runs at a time.
  always_ff @(posedge clk) begin
    if (!rd_n || !wr_n) begin
      run <= run + 6'h01;
    end else begin
      if (run != 6'h00) last_len <= run;
      run <= 6'h00;
    end
  end
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the auxiliary bus control block over AXI4-Lite.
// Assumes the design files and the memory model are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import abc_pkg::*;
  logic clk, rst_b, awvalid, wvalid, bready, arvalid, rready, dsm, cea, mreq, mwr, clr;
  logic awready, wready, bvalid, arready, rvalid, busy, estb, ale, aoe, apu, rd_n, wr_n, pu;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [10:0] esize;
  logic [5:0] slen;
  logic [15:0] acnt;
  int n_mismatch = 0;
  int n_checks = 0;
  abc_top dut (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .double_speed_mode(dsm),
    .code_ext_active(cea), .external_data_move_req(mreq), .external_data_move_write(mwr), .external_data_move_busy(busy), .expanded_ram_stb(estb),
    .expanded_ram_size_bytes(esize), .ale_out(ale), .ale_oe(aoe), .ale_pullup(apu), .rd_n(rd_n),
    .wr_n(wr_n), .pullup_en(pu));
  abc_mem_model mem (.clk(clk), .clr(clr), .ale_out(ale), .ale_oe(aoe), .ale_pullup(apu),
    .rd_n(rd_n), .wr_n(wr_n), .last_len(slen), .ale_cnt(acnt));
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Each bus task lets an edge pass first, so no signal is assigned twice in one step.
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    int t;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && t < 50);
    if (t >= 50) n_mismatch++;
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] ed, input logic [1:0] er);
    int t;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && t < 50);
    if (t >= 50) n_mismatch++;
    chk(rdata, {24'h00_0000, ed});
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  // Counts driven latch pulses over exactly 30 clocks.
  task automatic ale_chk(input logic [15:0] e);
    repeat (8) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (31) @(posedge clk);
    chk({16'h0000, acnt}, {16'h0000, e});
  endtask
  // One data move; es high means it must go to internal RAM, el is the strobe length.
  task automatic mv(input logic w, input logic es, input logic [5:0] el);
    int t;
    @(posedge clk);
    mreq <= 1'b1;
    mwr <= w;
    @(posedge clk);
    mreq <= 1'b0;
    @(posedge clk);
    chk({30'h0, estb, w ? wr_n : rd_n}, {30'h0, es, es});
    t = 0;
    while (busy !== 1'b0 && t < 40) begin
      @(posedge clk);
      t++;
    end
    if (t >= 40) n_mismatch++;
    repeat (2) @(posedge clk);
    if (!es) chk({26'h0, slen}, {26'h0, el});
  endtask
  // The clock toggles every half period of 20 ns.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Hang guard, well beyond the few hundred clocks the tests need.
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
  // Main sequence.
  initial begin
    {rst_b, awvalid, wvalid, arvalid, dsm, cea, mreq, mwr, clr} = 9'h000;
    {bready, rready} = 2'b11;
    {awaddr, araddr, wdata} = 56'h0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd(12'h238, 8'h0C, 2'h0);
    chk({20'h0_0000, esize, pu}, {20'h0_0000, 11'h400, 1'b1});
    rd(12'h000, 8'h00, 2'h2);
    wr(12'h000, 8'h00, 2'h2);
    ale_chk(16'h0005);
    dsm <= 1'b1;
    ale_chk(16'h000A);
    dsm <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      wr(12'h238, 8'(i << 2), 2'h0);
      chk({21'h0, esize}, {21'h0, 11'(256 * (i + 1))});
    end
    wr(12'h238, 8'h8C, 2'h0);
    chk({31'h0, pu}, 32'h0000_0000);
    rd(12'h238, 8'h8C, 2'h0);
    wr(12'h238, 8'h0D, 2'h0);
    ale_chk(16'h0000);
    chk({30'h0, aoe, apu}, 32'h0000_0001);
    rd(12'h23C, 8'h00, 2'h0);
    wr(12'h23C, 8'hFF, 2'h0);
    rd(12'h238, 8'h0D, 2'h0);
    cea <= 1'b1;
    ale_chk(16'h0005);
    cea <= 1'b0;
    wr(12'h238, 8'h0E, 2'h0);
    mv(1'b0, 1'b0, 6'h06);
    mv(1'b1, 1'b0, 6'h06);
    wr(12'h238, 8'h2E, 2'h0);
    mv(1'b0, 1'b0, 6'h1E);
    wr(12'h238, 8'h0C, 2'h0);
    mv(1'b1, 1'b1, 6'h00);
    conclude();
  end
endmodule
`default_nettype wire
